// >>> hdl/stg_gate_top.sv
// Purpose: spanning tree state gating of forwarding, reception and learning
// Assumes: apb slave, zero wait states; lookup and mac logic on pclk
// Notes: decisions answer one cycle after a request
//
// What this block does
// R1 - each network port has tx, rx, learn-disable controls
// R2 - disable or discarding blocks user traffic both ways
// R3 - override static hits still reach the host
// R4 - blocking passes only override traffic to host
// R5 - listening and learning pass only host traffic
// R6 - learning state learns but forwards no user traffic
// R7 - forwarding state forwards, receives and learns normally
// R8 - learn disable suppresses dynamic entry learning
// R9 - flush bits clear port entries when learning disabled
// R10 - host sends nothing to disabled or blocking ports
// R11 - host discards override frames from discarding ports
// R12 - host loads override entries and may transmit later
// R13 - host tail tag low bits pick destination port
// R14 - control changes apply from the next packet

`timescale 1ns/100ps

module stg_gate_top
#(
  parameter int unsigned ADDR_W = stg_pkg::ADDR_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] rx_sof,
  input wire logic [1:0] rx_eof,
  input wire logic [1:0] tx_sof,
  input wire logic [1:0] tx_eof,
  input wire logic [1:0] tx_from_host,
  output logic [1:0] tx_allow,
  input wire logic req_valid,
  input wire stg_pkg::stg_fwd_req_s req,
  output logic dec_valid,
  output stg_pkg::stg_fwd_dec_s dec,
  output logic [1:0] flush_dyn_req,
  output logic [1:0] flush_sta_req,
  input wire logic [1:0] flush_dyn_done,
  input wire logic [1:0] flush_sta_done
);

  typedef struct packed {
    stg_pkg::stg_port_ctrl_s [1:0] ctrl;
    logic tail_en;
    logic [1:0] fl_dyn;
    logic [1:0] fl_sta;
    logic [31:0] rdata;
    logic dv;
    stg_pkg::stg_fwd_dec_s dec;
  } stg_top_s;

  stg_top_s st_reg;
  stg_top_s st_next;
  stg_pkg::stg_port_ctrl_s [1:0] rx_ctrl;
  logic [1:0] allow;

  // ==========================================================
  // per-port packet boundary snapshots
  // a frame keeps the setting it started with, whatever software writes
  genvar gp;
  generate
    for (gp = 0; gp < stg_pkg::NPORT; gp++)
    begin : g_port
      stg_port_gate u_gate
      (
        .pclk(pclk),
        .presetn(presetn),
        .ctrl(st_reg.ctrl[gp]),
        .rx_sof(rx_sof[gp]),
        .rx_eof(rx_eof[gp]),
        .tx_sof(tx_sof[gp]),
        .tx_eof(tx_eof[gp]),
        .tx_from_host(tx_from_host[gp]),
        .rx_ctrl(rx_ctrl[gp]),
        .tx_allow(allow[gp])
      );
    end
  endgenerate

  // ==========================================================
  // helpers
  // listening, blocking and disable share one setting: software keeps
  // track of which of them it means
  function automatic logic [1:0] class_of(input stg_pkg::stg_port_ctrl_s c);
    stg_pkg::stg_class_e k;
    k = stg_pkg::STP_OTHER;
    if (c.tx_en && c.rx_en && !c.lrn_dis)
    begin
      k = stg_pkg::STP_FWD;
    end
    else if (!c.tx_en && !c.rx_en && !c.lrn_dis)
    begin
      k = stg_pkg::STP_LRN;
    end
    else if (!c.tx_en && !c.rx_en)
    begin
      k = stg_pkg::STP_DISC;
    end
    return k;
  endfunction

  // only the low byte decodes; a wider bus aliases the map
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] a8;
    a8 = a[7:0];
    return (a8 == stg_pkg::OFS_P1_CTRL) || (a8 == stg_pkg::OFS_P2_CTRL)
      || (a8 == stg_pkg::OFS_GLB_CTRL) || (a8 == stg_pkg::OFS_STATUS);
  endfunction

  // ==========================================================
  // apb handshake
  logic acc;
  logic wr;
  logic [7:0] a8;

  assign a8 = paddr[7:0];
  assign acc = psel & penable;
  assign wr = acc & pwrite & addr_hit(paddr);
  // no wait states: read data is prepared in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_hit(paddr);
  // writes to the read-only status word are dropped without an error

  // ==========================================================
  // next state
  always_comb
  begin
    logic [31:0] rd;
    logic [2:0] m;
    logic lrn;
    int unsigned p;
    int unsigned o;
    rd = 32'h0000_0000;
    m = stg_pkg::MASK_NONE;
    lrn = 1'b1;
    p = 0;
    o = 1;
    st_next = st_reg;

    // flush completion first, so a fresh write still sets the bit
    for (int i = 0; i < stg_pkg::NPORT; i++)
    begin
      if (flush_dyn_done[i])
      begin
        st_next.fl_dyn[i] = 1'b0;
      end
      if (flush_sta_done[i])
      begin
        st_next.fl_sta[i] = 1'b0;
      end
    end

    if (wr && pstrb[0] && a8 == stg_pkg::OFS_P1_CTRL)
    begin
      st_next.ctrl[0] = pwdata[stg_pkg::BIT_TX_EN:stg_pkg::BIT_LRN_DIS]; // R1
    end
    if (wr && pstrb[0] && a8 == stg_pkg::OFS_P2_CTRL)
    begin
      st_next.ctrl[1] = pwdata[stg_pkg::BIT_TX_EN:stg_pkg::BIT_LRN_DIS]; // R1
    end
    // one write starts a flush; the bits read back as pending until done
    if (wr && pstrb[1] && a8 == stg_pkg::OFS_GLB_CTRL)
    begin
      st_next.tail_en = pwdata[stg_pkg::BIT_TAIL_EN];
      for (int i = 0; i < stg_pkg::NPORT; i++)
      begin
        // only ports with learning off are flushed
        if (pwdata[stg_pkg::BIT_FL_DYN] && st_reg.ctrl[i].lrn_dis)
        begin
          st_next.fl_dyn[i] = 1'b1; // R9
        end
        if (pwdata[stg_pkg::BIT_FL_STA] && st_reg.ctrl[i].lrn_dis)
        begin
          st_next.fl_sta[i] = 1'b1; // R9
        end
      end
    end

    // read mux, captured in the setup cycle
    case (a8)
      stg_pkg::OFS_P1_CTRL:
      begin
        rd[stg_pkg::BIT_TX_EN:stg_pkg::BIT_LRN_DIS] = st_reg.ctrl[0];
      end
      stg_pkg::OFS_P2_CTRL:
      begin
        rd[stg_pkg::BIT_TX_EN:stg_pkg::BIT_LRN_DIS] = st_reg.ctrl[1];
      end
      stg_pkg::OFS_GLB_CTRL:
      begin
        rd[stg_pkg::BIT_TAIL_EN] = st_reg.tail_en;
        rd[stg_pkg::BIT_FL_DYN] = |st_reg.fl_dyn;
        rd[stg_pkg::BIT_FL_STA] = |st_reg.fl_sta;
      end
      stg_pkg::OFS_STATUS:
      begin
        // taken in the setup cycle, so it may lag a change by one clock
        rd[stg_pkg::ST_CLASS_LSB +: 2] = class_of(st_reg.ctrl[0]);
        rd[stg_pkg::ST_CLASS_LSB + 2 +: 2] = class_of(st_reg.ctrl[1]);
        rd[stg_pkg::ST_ALLOW_LSB +: 2] = allow;
        rd[stg_pkg::ST_FLDYN_LSB +: 2] = st_reg.fl_dyn;
        rd[stg_pkg::ST_FLSTA_LSB +: 2] = st_reg.fl_sta;
      end
      default:
      begin
        rd = 32'h0000_0000;
      end
    endcase
    if (psel && !penable && !pwrite)
    begin
      st_next.rdata = rd;
    end

    // forwarding decision
    if (req.src == stg_pkg::SRC_HOST)
    begin
      if (st_reg.tail_en && req.tag != stg_pkg::TAG_LOOKUP)
      begin
        // directed frames skip lookup and the tx gate
        // (the host keeps them away from blocked ports)
        m = {1'b0, req.tag}; // R13 R12
      end
      else
      begin
        m = req.ptf1 & {1'b0, st_reg.ctrl[1].tx_en, st_reg.ctrl[0].tx_en}; // R2 R5
      end
      lrn = 1'b1;
    end
    else
    begin
      p = (req.src == 2'h1) ? 1 : 0;
      o = 1 - p;
      // ingress uses the frame snapshot, egress the live enable; the tx
      // gate of the other port holds a frame already on its way out
      if (rx_ctrl[p].rx_en)
      begin
        m = req.ptf1; // R7
        m[o] = req.ptf1[o] & st_reg.ctrl[o].tx_en; // R5 R6
        m[p] = 1'b0;
      end
      else if (req.ovr)
      begin
        // frames the host asked for, even while receive is off
        m = stg_pkg::MASK_HOST; // R3 R4 R5
      end
      else
      begin
        m = stg_pkg::MASK_NONE; // R2 R4 R6
      end
      lrn = ~rx_ctrl[p].lrn_dis; // R6 R7 R8
    end
    st_next.dv = req_valid;
    if (req_valid)
    begin
      st_next.dec.ptf2 = m;
      st_next.dec.learn = lrn;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // both ports come up forwarding, so an unconfigured switch bridges
      st_reg.ctrl[0] <= stg_pkg::CTRL_RST;
      st_reg.ctrl[1] <= stg_pkg::CTRL_RST;
      st_reg.tail_en <= stg_pkg::TAIL_EN_RST;
      st_reg.fl_dyn <= 2'h0;
      st_reg.fl_sta <= 2'h0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.dv <= 1'b0;
      st_reg.dec <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st_reg.rdata;
  // dec holds until the next request; only dec_valid pulses
  assign dec_valid = st_reg.dv;
  assign dec = st_reg.dec;
  assign tx_allow = allow;
  // held until the table engine reports the port done
  assign flush_dyn_req = st_reg.fl_dyn;
  assign flush_sta_req = st_reg.fl_sta;

endmodule

// >>> hdl/stg_pkg.sv
// Purpose: shared constants and carriers for the spanning tree port gate
// Assumes: apb with 32-bit data, byte addressed, one word per register
// Notes: port mask bit 0 is port 1, bit 1 port 2, bit 2 the host port

package stg_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_P1_CTRL = 8'h00;
  localparam logic [7:0] OFS_P2_CTRL = 8'h04;
  localparam logic [7:0] OFS_GLB_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // ==========================================================
  // port control fields (port_one_ctrl_reg_b / port_two_ctrl_reg_b)
  localparam int unsigned BIT_LRN_DIS = 0;
  localparam int unsigned BIT_RX_EN = 1;
  localparam int unsigned BIT_TX_EN = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;

  // ==========================================================
  // global control fields (switch_global_ctrl_h)
  localparam int unsigned BIT_TAIL_EN = 8;
  localparam int unsigned BIT_FL_DYN = 9;
  localparam int unsigned BIT_FL_STA = 10;
  localparam logic TAIL_EN_RST = 1'b0;

  // ==========================================================
  // status fields
  localparam int unsigned ST_CLASS_LSB = 0;
  localparam int unsigned ST_ALLOW_LSB = 4;
  localparam int unsigned ST_FLDYN_LSB = 6;
  localparam int unsigned ST_FLSTA_LSB = 8;

  // ==========================================================
  // forwarding masks, sources, tail tag codes
  localparam int unsigned NPORT = 2;
  localparam int unsigned MSK_HOST = 2;
  localparam logic [2:0] MASK_HOST = 3'h4;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [1:0] SRC_HOST = 2'h2;
  localparam logic [1:0] TAG_LOOKUP = 2'h0;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic lrn_dis;
  } stg_port_ctrl_s;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] ptf1;
    logic ovr;
    logic [1:0] tag;
  } stg_fwd_req_s;

  typedef struct packed {
    logic [2:0] ptf2;
    logic learn;
  } stg_fwd_dec_s;

  typedef enum logic [1:0] {
    STP_FWD,
    STP_LRN,
    STP_DISC,
    STP_OTHER
  } stg_class_e;

endpackage

// >>> hdl/stg_port_gate.sv
// Purpose: per-port snapshot of state controls at packet boundaries
// Assumes: sof/eof are single-cycle pulses from same-clock mac logic
// Notes: live controls are taken only between packets

`timescale 1ns/100ps

module stg_port_gate
(
  input wire logic pclk,
  input wire logic presetn,
  input wire stg_pkg::stg_port_ctrl_s ctrl,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic tx_sof,
  input wire logic tx_eof,
  input wire logic tx_from_host,
  output stg_pkg::stg_port_ctrl_s rx_ctrl,
  output logic tx_allow
);

  typedef struct packed {
    stg_pkg::stg_port_ctrl_s snap;
    logic rx_busy;
    logic allow;
    logic tx_busy;
  } stg_gate_s;

  stg_gate_s st_reg;
  stg_gate_s st_next;

  // ==========================================================
  // snapshot logic
  always_comb
  begin
    st_next = st_reg;
    // a packet in flight keeps the setting it started with
    if (rx_sof || !st_reg.rx_busy)
    begin
      st_next.snap = ctrl; // R14
    end
    if (rx_sof)
    begin
      st_next.rx_busy = 1'b1;
    end
    else if (rx_eof)
    begin
      st_next.rx_busy = 1'b0;
    end
    // host-directed frames may still leave in listening or learning
    if (tx_sof)
    begin
      st_next.allow = ctrl.tx_en | tx_from_host; // R14 R5
      st_next.tx_busy = 1'b1;
    end
    else if (!st_reg.tx_busy)
    begin
      st_next.allow = ctrl.tx_en; // R2
    end
    if (!tx_sof && tx_eof)
    begin
      st_next.tx_busy = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{snap: stg_pkg::CTRL_RST, rx_busy: 1'b0, allow: 1'b1, tx_busy: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rx_ctrl = st_reg.snap;
  assign tx_allow = st_reg.allow;

endmodule

// >>> tb/stg_gate_asserts.sv
// Purpose: port checks for stg_gate_top
// Assumes: one pclk domain
// Notes: bound by name
`timescale 1ns/100ps
module stg_gate_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [1:0] tx_sof,
  input wire logic [1:0] tx_from_host,
  input wire logic [1:0] tx_allow,
  input wire logic req_valid,
  input wire stg_pkg::stg_fwd_req_s req,
  input wire logic dec_valid,
  input wire stg_pkg::stg_fwd_dec_s dec,
  input wire logic [1:0] flush_dyn_req,
  input wire logic [1:0] flush_sta_req,
  input wire logic [1:0] flush_sta_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // decisions and the tx gate
  a_dec_follows: assert property (req_valid |=> dec_valid)
    else $error("no decision");
  a_dec_quiet: assert property (!req_valid |=> !dec_valid)
    else $error("stray decision");
  a_no_new_port: assert property (req_valid && req.src != 2'h2 && !req.ovr
    |=> (dec.ptf2 & ~$past(req.ptf1)) == 3'h0) else $error("port added");
  a_ovr_host: assert property (req_valid && req.src != 2'h2 && req.ovr
    && req.ptf1[2] |=> dec.ptf2[2]) else $error("override lost");
  a_src_never: assert property (req_valid && req.src == 2'h0 |=> !dec.ptf2[0])
    else $error("sent back to source");
  a_host_learn: assert property (req_valid && req.src == 2'h2
    |=> dec.learn && !dec.ptf2[2]) else $error("host decision");
  a_tx_host: assert property (tx_sof[0] && tx_from_host[0] |=> tx_allow[0])
    else $error("host frame blocked");
  // ====
  // flush, then covers
  a_flush_hold: assert property (flush_sta_req[0] && !flush_sta_done[0]
    |=> flush_sta_req[0]) else $error("flush dropped");
  a_flush_cause: assert property ($rose(flush_dyn_req[1])
    |-> $past(psel && penable && pwrite)) else $error("flush without write");
  c_ovr: cover property (req_valid && req.ovr);
  c_flush: cover property (flush_sta_done[0]);
  c_tx: cover property (tx_sof[0]);
endmodule
bind stg_gate_top stg_gate_asserts u_chk (.*);

// >>> tb/stg_table_model.sv
// Purpose: table engine stand-in answering flush requests
// Assumes: requests are levels held until done
// Notes: DLY sets a prompt or slow answer
`timescale 1ns/100ps
module stg_table_model
#(
  parameter int unsigned DLY = 3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] flush_dyn_req,
  input wire logic [1:0] flush_sta_req,
  output logic [1:0] flush_dyn_done,
  output logic [1:0] flush_sta_done
);
  logic [3:0] rq;
  logic [3:0] dn;
  logic [3:0][7:0] cnt;
  assign rq = {flush_sta_req, flush_dyn_req};
  assign {flush_sta_done, flush_dyn_done} = dn;
  // ====
  // one counter per port and table
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dn <= '0;
      cnt <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        dn[i] <= rq[i] && !dn[i] && cnt[i] == 8'(DLY);
        cnt[i] <= (rq[i] && !dn[i]) ? cnt[i] + 8'h1 : 8'h0;
      end
    end
  end
endmodule

// >>> tb/stg_gate_top_tb.sv
// Purpose: self-checking bench for stg_gate_top
// Assumes: zero-wait apb, table stand-in on flush
// Notes: port 1 walks through the states
`timescale 1ns/100ps
module stg_gate_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic req_valid, dec_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] rx_sof, rx_eof, tx_sof, tx_eof, tx_from_host, tx_allow;
  logic [1:0] flush_dyn_req, flush_sta_req, flush_dyn_done, flush_sta_done;
  stg_pkg::stg_fwd_req_s req;
  stg_pkg::stg_fwd_dec_s dec;
  int n_errors, checks_done;
  stg_gate_top DUT (.*);
  stg_table_model u_tbl (.*);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ====
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {2'h0, w, w};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic dq(input logic [1:0] s, input logic [2:0] p, input logic o,
    input logic [1:0] t, input logic [3:0] e);
    req_valid <= 1'b1;
    req <= {s, p, o, t};
    @(posedge pclk);
    req_valid <= 1'b0;
    #1;
    chk(dec_valid, 1'b1);
    chk(dec, e);
    @(posedge pclk);
  endtask
  task automatic rx(input logic [1:0] m, input logic eof);
    if (eof) rx_eof <= m;
    else rx_sof <= m;
    @(posedge pclk);
    rx_sof <= 2'h0;
    rx_eof <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic tx(input logic [1:0] h, input logic eof);
    tx_from_host <= h;
    if (eof) tx_eof <= 2'h1;
    else tx_sof <= 2'h1;
    @(posedge pclk);
    tx_sof <= 2'h0;
    tx_eof <= 2'h0;
    @(posedge pclk);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    apb(1'b0, stg_pkg::OFS_P1_CTRL, 32'h0);
    chk(rd, {29'h0, stg_pkg::CTRL_RST});
    apb(1'b0, stg_pkg::OFS_P2_CTRL, 32'h0);
    chk(rd, {29'h0, stg_pkg::CTRL_RST});
    chk(tx_allow, 2'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    $display("t_reset end");
  endtask
  task automatic t_states;
    logic [2:0] c;
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 3'h1 : (i == 1) ? 3'h0 : 3'h6;
      apb(1'b1, stg_pkg::OFS_P1_CTRL, {29'h0, c});
      rx(2'h1, 1'b0);
      dq(2'h0, 3'h2, 1'b0, 2'h0, {c[1] ? 3'h2 : 3'h0, !c[0]});
      dq(2'h0, 3'h6, 1'b1, 2'h0, {c[1] ? 3'h6 : 3'h4, !c[0]});
      rx(2'h1, 1'b1);
      rx(2'h2, 1'b0);
      dq(2'h1, 3'h1, 1'b0, 2'h0, {2'h0, c[2], 1'b1});
      rx(2'h2, 1'b1);
    end
    $display("t_states end");
  endtask
  task automatic t_tx;
    apb(1'b1, stg_pkg::OFS_P1_CTRL, 32'h0);
    tx(2'h1, 1'b0);
    chk(tx_allow[0], 1'b1);
    tx(2'h0, 1'b1);
    tx(2'h0, 1'b0);
    apb(1'b1, stg_pkg::OFS_P1_CTRL, 32'h6);
    chk(tx_allow[0], 1'b0);
    tx(2'h0, 1'b1);
    @(posedge pclk);
    chk(tx_allow[0], 1'b1);
    $display("t_tx end");
  endtask
  task automatic t_flush;
    apb(1'b1, stg_pkg::OFS_P1_CTRL, 32'h1);
    apb(1'b1, stg_pkg::OFS_GLB_CTRL, 32'h600);
    chk({flush_sta_req, flush_dyn_req}, 4'h5);
    apb(1'b0, stg_pkg::OFS_STATUS, 32'h0);
    chk(rd, {22'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2});
    for (int i = 0; i < 20 && (flush_sta_req | flush_dyn_req) != 2'h0; i++)
      @(posedge pclk);
    chk({flush_sta_req, flush_dyn_req}, 4'h0);
    apb(1'b1, stg_pkg::OFS_P2_CTRL, 32'h1);
    apb(1'b1, stg_pkg::OFS_GLB_CTRL, 32'h200);
    chk({flush_sta_req, flush_dyn_req}, 4'h3);
    for (int i = 0; i < 20 && (flush_sta_req | flush_dyn_req) != 2'h0; i++)
      @(posedge pclk);
    chk({flush_sta_req, flush_dyn_req}, 4'h0);
    $display("t_flush end");
  endtask
  task automatic t_tag;
    apb(1'b1, stg_pkg::OFS_P1_CTRL, 32'h0);
    apb(1'b1, stg_pkg::OFS_P2_CTRL, 32'h6);
    apb(1'b1, stg_pkg::OFS_GLB_CTRL, 32'h100);
    for (int t = 1; t < 4; t++)
      dq(stg_pkg::SRC_HOST, 3'h0, 1'b0, t[1:0], {1'b0, t[1:0], 1'b1});
    dq(stg_pkg::SRC_HOST, 3'h3, 1'b0, 2'h0, 4'h5);
    $display("t_tag end");
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, req_valid, paddr, pwdata, pstrb} = '0;
    {rx_sof, rx_eof, tx_sof, tx_eof, tx_from_host, req} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_states;
    t_tx;
    t_flush;
    t_tag;
    results;
  end
  initial
  begin
    #20000;
    n_errors++;
    results;
  end
endmodule
